// ### design/pcd_defs.svh
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH

// Printed offsets are not all multiples of four: index, byte address = 4 * index
`define PCD_IDX_PC_DATA   4'h2
`define PCD_IDX_PD_DATA   4'h3
`define PCD_IDX_PC_DIR    4'h6
`define PCD_IDX_PD_DIR    4'h7
`define PCD_IDX_ADC_SEL   4'h8
`define PCD_IDX_TMR_SEL   4'h9

`define PCD_PC_W          6
`define PCD_PD_W          8
`define PCD_CLKOUT_BIT    7
`define PCD_CLKOUT_PIN    2
`define PCD_ADC_BASE      5'h08
`define PCD_ADC_PINS      7
`define PCD_T1_PIN        6
`define PCD_T2_PIN        4
`define PCD_PS_EXT        3'h7
`define PCD_DIR_RST       8'h00
`define PCD_PIN_W         14
`define PCD_ADC_SEL_W     5
`define PCD_ADC_SEL_RST   5'h1f
`define PCD_PS_W          3
`define PCD_PS1_LSB       0
`define PCD_PS2_LSB       4
`define PCD_PS_RST        3'h0
`define PCD_RESP_OKAY     2'h0
`define PCD_RESP_SLVERR   2'h2

`endif

// ### design/pcd_pkg.sv
package pcd_pkg;
	typedef struct packed {
		logic [7:0] pc_out;
		logic [7:0] pc_oe;
		logic [7:0] pd_out;
		logic [7:0] pd_oe;
	} pcd_pins_s;

	typedef enum logic [1:0] {
		PCD_IDLE = 2'b01,
		PCD_RESP = 2'b10
	} pcd_state_e;
endpackage

// ### design/pcd_gpio.sv
`include "pcd_defs.svh"

module pcd_gpio (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [5:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [5:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Pins
	input  wire logic [5:0]        port_c_in,
	input  wire logic [7:0]        port_d_in,
	output pcd_pkg::pcd_pins_s     pins
);
	// Register state
	logic [5:0]              pc_latch_r;
	logic [7:0]              pd_latch_r;
	logic [5:0]              pc_dir_r;
	logic                    clock_out_enable_r;
	logic [7:0]              pd_dir_r;
	logic [4:0]              converter_channel_select_r;
	logic [2:0]              timer_one_prescaler_select_r;
	logic [2:0]              timer_two_prescaler_select_r;
	logic [5:0]              aw_addr_r;
	logic                    aw_have_r;
	logic [31:0]             w_data_r;
	logic                    w_strb0_r;
	logic                    w_have_r;
	pcd_pkg::pcd_state_e     wr_state_r;
	pcd_pkg::pcd_state_e     rd_state_r;
	logic [1:0]              bresp_r;
	logic [31:0]             rdata_r;
	logic [1:0]              rresp_r;
	// Three-stage pin samplers
	logic [`PCD_PIN_W-1:0]   sync1_r;
	logic [`PCD_PIN_W-1:0]   sync2_r;
	logic [`PCD_PIN_W-1:0]   sync3_r;
	logic [`PCD_PIN_W-1:0]   pin_level_r;

	// Pin sampling: change accepted once stages two and three agree
	// Stage one may go metastable, so only stage two reads it
	always_ff @(posedge aclk) begin
		sync1_r <= {port_d_in, port_c_in};
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	// Pads read low after reset until a level has settled
	genvar gi;
	generate
		for (gi = 0; gi < `PCD_PIN_W; gi++) begin : g_filt
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_level_r[gi] <= 1'b0;
				end else if (sync2_r[gi] == sync3_r[gi]) begin
					pin_level_r[gi] <= sync3_r[gi];
				end
			end
		end
	endgenerate

	wire [5:0] pc_pin = pin_level_r[5:0];
	wire [7:0] pd_pin = pin_level_r[13:6];

	// Converter and timer claims on port D
	// Channels from the base value up land on D0 to D6 in order
	wire [4:0] adc_off = converter_channel_select_r - `PCD_ADC_BASE;
	wire       adc_hit = (converter_channel_select_r >= `PCD_ADC_BASE)
		&& (adc_off < 5'(`PCD_ADC_PINS));
	wire [7:0] adc_claim = adc_hit ? 8'(8'h01 << adc_off[2:0]) : 8'h00;
	wire t1_ext = (timer_one_prescaler_select_r == `PCD_PS_EXT);
	wire t2_ext = (timer_two_prescaler_select_r == `PCD_PS_EXT);
	wire [7:0] tmr_claim = (8'(t1_ext) << `PCD_T1_PIN)
		| (8'(t2_ext) << `PCD_T2_PIN);
	wire [7:0] pd_claim = adc_claim | tmr_claim;

	// Pin drive
	// Clock-out goes through a gate, not a flop: a flop cannot follow both edges,
	// so the pad carries the gate's delay as skew against the internal clock
	logic [5:0] pc_oe;
	logic [5:0] pc_out;
	always_comb begin
		pc_oe  = pc_dir_r;
		pc_out = pc_latch_r;
		if (clock_out_enable_r) begin
			pc_oe[`PCD_CLKOUT_PIN]  = 1'b1;
			pc_out[`PCD_CLKOUT_PIN] = aclk;
		end
	end
	// Claimed pins are inputs to their owners; direction bits ignored
	assign pins.pc_out = {2'b00, pc_out};
	assign pins.pc_oe  = {2'b00, pc_oe};
	assign pins.pd_out = pd_latch_r;
	assign pins.pd_oe  = pd_dir_r & ~pd_claim;

	// Readback values, one bit at a time
	wire [5:0] pc_read;
	wire [7:0] pd_read;
	genvar gc;
	generate
		for (gc = 0; gc < `PCD_PC_W; gc++) begin : g_pc_rd
			assign pc_read[gc] = pc_dir_r[gc] ? pc_latch_r[gc] : pc_pin[gc];
		end
	endgenerate
	// A claimed bit never shows the pad: its owner may hold it at any level
	genvar gd;
	generate
		for (gd = 0; gd < `PCD_PD_W; gd++) begin : g_pd_rd
			wire gpio_bit = pd_dir_r[gd] ? pd_latch_r[gd] : pd_pin[gd];
			wire own_bit  = pd_dir_r[gd] & pd_latch_r[gd];
			assign pd_read[gd] = pd_claim[gd] ? own_bit : gpio_bit;
		end
	endgenerate
	wire [7:0] pc_dir_read = {clock_out_enable_r, 1'b0, pc_dir_r};
	wire [7:0] tmr_read    = {1'b0, timer_two_prescaler_select_r,
		1'b0, timer_one_prescaler_select_r};

	// Read decode
	// Unmapped words answer SLVERR and read as zero
	wire [3:0] ar_idx = s_axi_araddr[5:2];
	wire       ar_ok  = (ar_idx == `PCD_IDX_PC_DATA) || (ar_idx == `PCD_IDX_PD_DATA)
		|| (ar_idx == `PCD_IDX_PC_DIR) || (ar_idx == `PCD_IDX_PD_DIR)
		|| (ar_idx == `PCD_IDX_ADC_SEL) || (ar_idx == `PCD_IDX_TMR_SEL);
	logic [7:0] rd_val;
	always_comb begin
		if (ar_idx == `PCD_IDX_PC_DATA) begin
			rd_val = {2'b00, pc_read};
		end else if (ar_idx == `PCD_IDX_PD_DATA) begin
			rd_val = pd_read;
		end else if (ar_idx == `PCD_IDX_PC_DIR) begin
			rd_val = pc_dir_read;
		end else if (ar_idx == `PCD_IDX_PD_DIR) begin
			rd_val = pd_dir_r;
		end else if (ar_idx == `PCD_IDX_ADC_SEL) begin
			rd_val = {3'b000, converter_channel_select_r};
		end else if (ar_idx == `PCD_IDX_TMR_SEL) begin
			rd_val = tmr_read;
		end else begin
			rd_val = 8'h00;
		end
	end

	// Write decode: fires when address and data are both held
	// With byte lane zero off a mapped write is answered OKAY and changes nothing
	wire       wr_go  = aw_have_r && w_have_r && (wr_state_r == pcd_pkg::PCD_IDLE);
	wire [3:0] aw_idx = aw_addr_r[5:2];
	wire       wr_en  = wr_go && w_strb0_r;
	wire       we_pc  = wr_en && (aw_idx == `PCD_IDX_PC_DATA);
	wire       we_pd  = wr_en && (aw_idx == `PCD_IDX_PD_DATA);
	wire       we_pcd = wr_en && (aw_idx == `PCD_IDX_PC_DIR);
	wire       we_pdd = wr_en && (aw_idx == `PCD_IDX_PD_DIR);
	wire       we_adc = wr_en && (aw_idx == `PCD_IDX_ADC_SEL);
	wire       we_tmr = wr_en && (aw_idx == `PCD_IDX_TMR_SEL);
	wire       aw_ok  = (aw_idx == `PCD_IDX_PC_DATA) || (aw_idx == `PCD_IDX_PD_DATA)
		|| (aw_idx == `PCD_IDX_PC_DIR) || (aw_idx == `PCD_IDX_PD_DIR)
		|| (aw_idx == `PCD_IDX_ADC_SEL) || (aw_idx == `PCD_IDX_TMR_SEL);

	// Data latches have no reset, so power-up contents are unknown
	always_ff @(posedge aclk) begin
		if (we_pc) begin
			pc_latch_r <= w_data_r[5:0];
		end
		if (we_pd) begin
			pd_latch_r <= w_data_r[7:0];
		end
	end

	// Fields of the held write word
	wire [5:0] wd_pc_dir = w_data_r[`PCD_PC_W-1:0];
	wire       wd_clkout = w_data_r[`PCD_CLKOUT_BIT];
	wire [7:0] wd_byte   = w_data_r[`PCD_PD_W-1:0];
	wire [4:0] wd_adc    = w_data_r[`PCD_ADC_SEL_W-1:0];
	wire [2:0] wd_ps1    = w_data_r[`PCD_PS1_LSB +: `PCD_PS_W];
	wire [2:0] wd_ps2    = w_data_r[`PCD_PS2_LSB +: `PCD_PS_W];

	// Port C direction and clock-out enable share one register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_dir_r           <= `PCD_PC_W'(`PCD_DIR_RST);
			clock_out_enable_r <= 1'b0;
		end else if (we_pcd) begin
			pc_dir_r           <= wd_pc_dir;
			clock_out_enable_r <= wd_clkout;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_dir_r <= `PCD_DIR_RST;
		end else if (we_pdd) begin
			pd_dir_r <= wd_byte;
		end
	end

	// Selects reset to no converter channel and no external timer clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			converter_channel_select_r <= `PCD_ADC_SEL_RST;
		end else if (we_adc) begin
			converter_channel_select_r <= wd_adc;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_one_prescaler_select_r <= `PCD_PS_RST;
			timer_two_prescaler_select_r <= `PCD_PS_RST;
		end else if (we_tmr) begin
			timer_one_prescaler_select_r <= wd_ps1;
			timer_two_prescaler_select_r <= wd_ps2;
		end
	end

	// Write channel: address and data accepted in either order
	assign s_axi_awready = !aw_have_r && (wr_state_r == pcd_pkg::PCD_IDLE);
	assign s_axi_wready  = !w_have_r && (wr_state_r == pcd_pkg::PCD_IDLE);
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	// Holding registers: each channel is taken once, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 6'h00;
		end else if (aw_take) begin
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_strb0_r <= 1'b0;
		end else if (w_take) begin
			w_have_r  <= 1'b1;
			w_data_r  <= s_axi_wdata;
			w_strb0_r <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_have_r <= 1'b0;
		end
	end

	// Response stands until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= pcd_pkg::PCD_IDLE;
			bresp_r    <= `PCD_RESP_OKAY;
		end else begin
			case (wr_state_r)
				pcd_pkg::PCD_IDLE: begin
					if (wr_go) begin
						bresp_r    <= aw_ok ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
						wr_state_r <= pcd_pkg::PCD_RESP;
					end
				end
				pcd_pkg::PCD_RESP: begin
					if (s_axi_bready) begin
						wr_state_r <= pcd_pkg::PCD_IDLE;
					end
				end
				default: wr_state_r <= pcd_pkg::PCD_IDLE;
			endcase
		end
	end
	assign s_axi_bvalid = (wr_state_r == pcd_pkg::PCD_RESP);
	assign s_axi_bresp  = bresp_r;

	// Read channel: one cycle from address to data
	assign s_axi_arready = (rd_state_r == pcd_pkg::PCD_IDLE);
	wire ar_take = s_axi_arvalid && s_axi_arready;
	// Decode is combinational, so the word is captured at the taking edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_r <= 32'h0000_0000;
			rresp_r <= `PCD_RESP_OKAY;
		end else if (ar_take) begin
			rdata_r <= {24'h00_0000, rd_val};
			rresp_r <= ar_ok ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= pcd_pkg::PCD_IDLE;
		end else begin
			case (rd_state_r)
				pcd_pkg::PCD_IDLE: begin
					if (ar_take) begin
						rd_state_r <= pcd_pkg::PCD_RESP;
					end
				end
				pcd_pkg::PCD_RESP: begin
					if (s_axi_rready) begin
						rd_state_r <= pcd_pkg::PCD_IDLE;
					end
				end
				default: rd_state_r <= pcd_pkg::PCD_IDLE;
			endcase
		end
	end
	assign s_axi_rvalid = (rd_state_r == pcd_pkg::PCD_RESP);
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;
endmodule

// ### tb/pcd_gpio_properties.sv
module pcd_gpio_properties (
	// Clock and reset
	input wire logic               aclk,
	input wire logic               aresetn,
	// Bus handshakes
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic [31:0]        s_axi_rdata,
	// Pads
	input wire pcd_pkg::pcd_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	oe_reset_a: assert property ($rose(aresetn) |-> pins.pc_oe == 8'h00 && pins.pd_oe == 8'h00)
		else $error("enables not clear after reset");
	pc_unused_a: assert property (pins.pc_oe[7:6] == 2'b00 && pins.pc_out[7:6] == 2'b00)
		else $error("unused port C pads driven");
	pc_oe_cause_a: assert property ($changed(pins.pc_oe) |-> $rose(s_axi_bvalid))
		else $error("port C enables moved without a write");
	pd_oe_cause_a: assert property ($changed(pins.pd_oe) |-> $rose(s_axi_bvalid))
		else $error("port D enables moved without a write");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer at wrong cycle");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	cover property (s_axi_bvalid && pins.pd_oe != 8'h00);
	cover property (pins.pc_oe[2]);
	cover property (s_axi_rvalid);
endmodule

bind pcd_gpio pcd_gpio_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rdata, .pins);

// ### tb/pcd_pin_model.sv
module pcd_pin_model (
	// Outside sources
	input  wire logic [7:0]         ext_c,
	input  wire logic [7:0]         ext_d,
	input  wire pcd_pkg::pcd_pins_s pins,
	// Pad levels
	output logic [5:0]              port_c_in,
	output logic [7:0]              port_d_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Driven pad shows its buffer, otherwise the outside source wins
	wire logic [7:0] c_lvl = (pins.pc_oe & pins.pc_out) | (~pins.pc_oe & ext_c);
	assign port_c_in = c_lvl[5:0];
	assign port_d_in = (pins.pd_oe & pins.pd_out) | (~pins.pd_oe & ext_d);
endmodule

// ### tb/testbench.sv
`include "pcd_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] A_PC = {`PCD_IDX_PC_DATA, 2'b00};
	localparam logic [5:0] A_PD = {`PCD_IDX_PD_DATA, 2'b00};
	localparam logic [5:0] A_CD = {`PCD_IDX_PC_DIR, 2'b00};
	localparam logic [5:0] A_DD = {`PCD_IDX_PD_DIR, 2'b00};
	localparam logic [5:0] A_AS = {`PCD_IDX_ADC_SEL, 2'b00};
	localparam logic [5:0] A_TS = {`PCD_IDX_TMR_SEL, 2'b00};
	localparam logic [1:0] OK = `PCD_RESP_OKAY;
	localparam logic [1:0] SE = `PCD_RESP_SLVERR;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0, port_c_in;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] port_d_in, ext_c = 8'h00, ext_d = 8'h00;
	pcd_pkg::pcd_pins_s pins;
	int error_cnt = 0, num_checks = 0;
	pcd_gpio uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_c_in,
		.port_d_in, .pins);
	pcd_pin_model pads (.ext_c, .ext_d, .pins, .port_c_in, .port_d_in);
	initial begin
		forever #5 aclk = ~aclk;
	end
	task automatic conclude();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tmo();
		error_cnt++;
		conclude();
	endtask
	// Ready and answers are judged at the falling edge, where they have settled
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = OK);
		logic ta, tw, dn;
		logic [1:0] r;
		dn = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !dn; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			dn = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (dn) s_axi_bready <= 1'b0;
		end
		if (!dn) tmo();
		chk(r, er);
	endtask
	// Waits out the four-edge pad sampling before reading
	task automatic rc(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er = OK);
		logic tk, dn;
		logic [31:0] d;
		logic [1:0] r;
		dn = 1'b0;
		repeat (5) @(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !dn; n++) begin
			@(negedge aclk);
			tk = s_axi_arvalid && s_axi_arready;
			dn = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (tk) s_axi_arvalid <= 1'b0;
			if (dn) s_axi_rready <= 1'b0;
		end
		if (!dn) tmo();
		chk(d, {24'h0, e});
		chk(r, er);
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(A_CD, 8'h00);
		rc(A_DD, 8'h00);
		chk(pins.pc_oe, 8'h00);
		chk(pins.pd_oe, 8'h00);
	endtask
	task automatic t_portc();
		ext_c <= 8'h15;
		wr(A_PC, 8'hff);
		rc(A_PC, 8'h15);
		wr(A_CD, 8'h0f);
		rc(A_PC, 8'h1f);
		chk(pins.pc_oe, 8'h0f);
		chk(pins.pc_out[3:0], 4'hf);
	endtask
	task automatic t_clkout();
		wr(A_CD, 8'hc0);
		rc(A_CD, 8'h80);
		chk(pins.pc_oe, 8'h04);
		@(negedge aclk);
		#2 chk(pins.pc_out[2], 1'b0);
		@(posedge aclk);
		#2 chk(pins.pc_out[2], 1'b1);
	endtask
	task automatic t_keep();
		wr(A_CD, 8'h3f);
		rc(A_PC, 8'h3f);
	endtask
	task automatic t_portd();
		ext_d <= 8'h3c;
		wr(A_PD, 8'ha5);
		wr(A_DD, 8'h0f);
		rc(A_PD, 8'h35);
		rc(A_DD, 8'h0f);
		chk(pins.pd_oe, 8'h0f);
		chk(pins.pd_out, 8'ha5);
	endtask
	task automatic t_conv();
		wr(A_AS, {3'h0, `PCD_ADC_BASE + 5'h05});
		rc(A_PD, 8'h15);
		wr(A_AS, {3'h0, `PCD_ADC_BASE});
		chk(pins.pd_oe, 8'h0e);
		rc(A_PD, 8'h35);
		wr(A_AS, 8'h1f);
		chk(pins.pd_oe, 8'h0f);
	endtask
	task automatic t_timer();
		wr(A_TS, 8'h77);
		wr(A_DD, 8'hff);
		chk(pins.pd_oe, 8'haf);
		rc(A_PD, 8'ha5);
		wr(A_DD, 8'h00);
		rc(A_PD, 8'h2c);
		wr(A_TS, 8'h00);
		wr(A_DD, 8'hff);
		chk(pins.pd_oe, 8'hff);
	endtask
	task automatic t_bad();
		wr(6'h3c, 8'hff, SE);
		rc(6'h3c, 8'h00, SE);
		s_axi_wstrb <= 4'h0;
		wr(A_DD, 8'h00);
		s_axi_wstrb <= 4'h1;
		rc(A_DD, 8'hff);
	endtask
	initial begin
		do_reset();
		t_portc();
		t_clkout();
		do_reset();
		t_keep();
		t_portd();
		t_conv();
		t_timer();
		t_bad();
		conclude();
	end
endmodule
